// >>> watch_tick_regs.svh
// register offsets, field positions, reset values and codes of the watch tick prescaler
`ifndef WATCH_TICK_REGS_SVH
`define WATCH_TICK_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CTRL_OFFSET      32'h0000_0000
`define CTRL_RMW_OFFSET  32'h0000_0004

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_RESET       8'h00
`define IEN_RESET        1'b0
`define SEL_RESET        3'h0
`define FLAG_BIT         7
`define IEN_BIT          6
`define SEL_MSB          3
`define SEL_LSB          1
`define CLR_BIT          0

// ****************************************************************
// counter and watchdog codes
// ****************************************************************
`define CNT_ALL_ONES     16'hFFFF
`define CNT_ZERO         16'h0000
`define WDT_SEL_PRESC_A  3'h4
`define WDT_SEL_PRESC_B  3'h6

// ****************************************************************
// bus answers
// ****************************************************************
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// >>> watch_tick_pkg.sv
// types shared by the watch tick prescaler modules
`default_nettype none

package watch_tick_pkg;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_SUB_OSC = 2'b01,
    SRC_SUB_RC  = 2'b10
  } count_source_t;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;

endpackage

`default_nettype wire

// >>> count_link_if.sv
// signals between the control logic, the count source and the interval counter
`timescale 1ns/1ps
`default_nettype none

interface count_link_if;
  logic        count_tick;
  logic        source_valid;
  logic        counter_clear;
  logic [2:0]  interval_select;
  logic        interval_event;
  logic [15:0] count_value;

  modport src (output count_tick, output source_valid);
  modport ctr (input count_tick, input counter_clear, input interval_select,
               output interval_event, output count_value);
  modport ctl (input count_tick, input source_valid, input interval_event,
               input count_value, output counter_clear, output interval_select);
endinterface

`default_nettype wire

// >>> count_source_select.sv
// picks the sub oscillator or sub rc pulses and divides them by two
`timescale 1ns/1ps
`default_nettype none

module count_source_select
  import watch_tick_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   ce,
  input  wire logic   sub_osc_pulse,
  input  wire logic   sub_rc_pulse,
  input  wire logic   sub_osc_ready,
  input  wire logic   sub_rc_ready,
  input  wire logic   halt,
  count_link_if.src   link
);

  count_source_t source;
  logic          half_phase;
  logic          src_pulse;

  // ****************************************************************
  // source choice
  // ****************************************************************
  // the oscillator wins when both are stable: it is the accurate one
  always_comb begin
    if (sub_osc_ready) begin
      source = SRC_SUB_OSC;
    end else if (sub_rc_ready) begin
      source = SRC_SUB_RC;
    end else begin
      source = SRC_NONE;
    end
  end

  always_comb begin
    case (source)
      SRC_SUB_OSC: src_pulse = sub_osc_pulse;
      SRC_SUB_RC:  src_pulse = sub_rc_pulse;
      default:     src_pulse = 1'b0;
    endcase
  end

  // ****************************************************************
  // divide by two
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_phase <= 1'b0;
    end else if (ce) begin
      if (halt || source == SRC_NONE) begin
        half_phase <= 1'b0;
      end else if (src_pulse) begin
        half_phase <= ~half_phase;
      end
    end
  end

  assign link.count_tick   = src_pulse & half_phase & ~halt;
  assign link.source_valid = (source != SRC_NONE);

endmodule

`default_nettype wire

// >>> interval_counter.sv
// down counter with wrap bit and selectable interval tap
`timescale 1ns/1ps
`default_nettype none

`include "watch_tick_regs.svh"

module interval_counter
  import watch_tick_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   ce,
  count_link_if.ctr   link
);

  logic [15:0] count;
  logic        wrap_bit;
  logic [16:0] tap_mask;
  logic        tap_hit;

  // ****************************************************************
  // counter
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count    <= `CNT_ALL_ONES;
      wrap_bit <= 1'b1;
    end else if (ce) begin
      if (link.counter_clear) begin
        count    <= `CNT_ALL_ONES;
        wrap_bit <= 1'b1;
      end else if (link.count_tick) begin
        count <= count - 16'h0001;
        if (count == `CNT_ZERO) begin
          wrap_bit <= ~wrap_bit;
        end
      end
    end
  end

  // ****************************************************************
  // interval tap
  // ****************************************************************
  always_comb begin
    case (link.interval_select)
      3'h4:    tap_mask = 17'h003FF;
      3'h0:    tap_mask = 17'h007FF;
      3'h1:    tap_mask = 17'h00FFF;
      3'h2:    tap_mask = 17'h01FFF;
      3'h3:    tap_mask = 17'h03FFF;
      3'h5:    tap_mask = 17'h07FFF;
      3'h6:    tap_mask = 17'h0FFFF;
      default: tap_mask = 17'h1FFFF;
    endcase
  end

  // the selected low bits wrap from all zeros to all ones on this tick
  assign tap_hit = link.count_tick & (({wrap_bit, count} & tap_mask) == 17'h00000);

  // registered so the flag logic sees a clean one cycle event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.interval_event <= 1'b0;
    end else if (ce) begin
      link.interval_event <= tap_hit & ~link.counter_clear;
    end
  end

  assign link.count_value = count;

endmodule

`default_nettype wire

// >>> watch_interval_prescaler.sv
// watch tick prescaler: control register, axi4-lite slave and watchdog coupling
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "watch_tick_regs.svh"

// Notes on behaviour
// - interval elapse sets pending flag always
// - request when flag and enable both one
// - read-modify-write read returns flag as one
// - write zero clears flag, one ignored
// - enable bit six is read/write
// - bits five and four read zero
// - three-bit select picks interval tap
// - clear bit sets whole counter to ones
// - clear bit is write-only, reads zero
// - prescaler clear also clears selected watchdog
// - keeps counting in stop from main clocks
// - watchdog clock restarts with watchdog cleared
// - sixteen-bit counter, subclock preferred, divided two
// - counts down from all ones, reloads
// - clear at overflow suppresses the flag
// - reset or sub stop entry clears counter
module watch_interval_prescaler
  import watch_tick_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // count sources and clock mode
  input  wire logic        sub_osc_pulse,
  input  wire logic        sub_rc_pulse,
  input  wire logic        sub_osc_ready,
  input  wire logic        sub_rc_ready,
  input  wire logic        sub_clock_mode,
  input  wire logic        stop_mode,
  // watchdog and interrupt controller
  input  wire logic [2:0]  watchdog_clock_select_ext,
  output logic             tick_irq,
  output logic             watchdog_clear,
  output logic             watchdog_clock
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  count_link_if link ();

  wr_state_t   wr_state;
  rd_state_t   rd_state;
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_hit;
  logic        ar_fire;
  logic        rd_hit_ctrl;
  logic        rd_hit_rmw;
  logic [7:0]  ctrl_view;

  logic        tick_pending_flag;
  logic        tick_irq_enable;
  logic [2:0]  interval_select;
  logic        sw_clear;
  logic        flag_clear;
  logic        stop_q;
  logic        stop_entry;
  logic        count_halt;
  logic        counter_clear;
  logic        wdt_uses_presc;
  logic        next_watchdog_clear;

  // ****************************************************************
  // submodules
  // ****************************************************************
  count_source_select u_source (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .sub_osc_pulse (sub_osc_pulse),
    .sub_rc_pulse  (sub_rc_pulse),
    .sub_osc_ready (sub_osc_ready),
    .sub_rc_ready  (sub_rc_ready),
    .halt          (count_halt),
    .link          (link.src)
  );

  interval_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .link    (link.ctr)
  );

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  // address and data are caught separately, so either may come first
  assign s_axi_awready = ce & (wr_state == WR_IDLE) & ~aw_held;
  assign s_axi_wready  = ce & (wr_state == WR_IDLE) & ~w_held;
  assign s_axi_bvalid  = ce & (wr_state == WR_RESP);
  assign wr_fire       = ce & (wr_state == WR_IDLE) & aw_held & w_held;
  assign wr_hit        = (aw_addr == `CTRL_OFFSET) | (aw_addr == `CTRL_RMW_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_state == WR_RESP && s_axi_bready) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_state == WR_RESP && s_axi_bready) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state    <= WR_IDLE;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state    <= WR_RESP;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign s_axi_arready = ce & (rd_state == RD_IDLE);
  assign s_axi_rvalid  = ce & (rd_state == RD_DATA);
  assign ar_fire       = s_axi_arvalid & s_axi_arready;
  assign rd_hit_ctrl   = (s_axi_araddr == `CTRL_OFFSET);
  assign rd_hit_rmw    = (s_axi_araddr == `CTRL_RMW_OFFSET);

  // reserved bits and the clear bit always read as zero
  assign ctrl_view = {tick_pending_flag, tick_irq_enable, 2'b00,
                      interval_select, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state    <= RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      case (rd_state)
        RD_IDLE: begin
          if (ar_fire) begin
            rd_state <= RD_DATA;
            if (rd_hit_ctrl) begin
              s_axi_rdata <= {24'h000000, ctrl_view};
              s_axi_rresp <= `RESP_OKAY;
            end else if (rd_hit_rmw) begin
              // the rmw alias lets a modify-write keep the flag untouched
              s_axi_rdata <= {24'h000000, 1'b1, ctrl_view[6:0]};
              s_axi_rresp <= `RESP_OKAY;
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= `RESP_SLVERR;
            end
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // control register fields
  // ****************************************************************
  assign flag_clear = wr_fire & wr_hit & w_strb[0] & ~w_data[`FLAG_BIT];
  assign sw_clear   = wr_fire & wr_hit & w_strb[0] & w_data[`CLR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_irq_enable <= `IEN_RESET;
      interval_select <= `SEL_RESET;
    end else if (ce) begin
      if (wr_fire && wr_hit && w_strb[0]) begin
        tick_irq_enable <= w_data[`IEN_BIT];
        interval_select <= w_data[`SEL_MSB:`SEL_LSB];
      end
    end
  end

  // a tick in the cycle of a clearing write still lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_pending_flag <= 1'b0;
    end else if (ce) begin
      if (link.interval_event) begin
        tick_pending_flag <= 1'b1;
      end else if (flag_clear) begin
        tick_pending_flag <= 1'b0;
      end
    end
  end

  // level request; stays high until the handler writes the flag or the enable to zero
  assign tick_irq = tick_pending_flag & tick_irq_enable;

  // ****************************************************************
  // clock mode handling
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q <= 1'b0;
    end else if (ce) begin
      stop_q <= stop_mode;
    end
  end

  // the sub clock stops in sub-mode stop; the main-clock stop keeps counting
  assign stop_entry = stop_mode & ~stop_q & sub_clock_mode;
  assign count_halt = stop_mode & sub_clock_mode;

  // a lost source forces a clear so counting restarts from a known phase
  assign counter_clear        = sw_clear | stop_entry | ~link.source_valid;
  assign link.counter_clear   = counter_clear;
  assign link.interval_select = interval_select;

  // ****************************************************************
  // watchdog coupling
  // ****************************************************************
  assign wdt_uses_presc = (watchdog_clock_select_ext == `WDT_SEL_PRESC_A) |
                          (watchdog_clock_select_ext == `WDT_SEL_PRESC_B);
  assign next_watchdog_clear = counter_clear & wdt_uses_presc;

  // registered, so it lines up with the counter reload at the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_clear <= 1'b0;
      watchdog_clock <= 1'b1;
    end else if (ce) begin
      watchdog_clear <= next_watchdog_clear;
      watchdog_clock <= counter_clear ? 1'b1 : link.count_value[15];
    end
  end

endmodule

`default_nettype wire

// >>> watch_tick_checker_asserts.sv
// port assertions of the watch tick prescaler
`timescale 1ns/1ps
`default_nettype none
`include "watch_tick_regs.svh"
module watch_tick_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  watchdog_clock_select_ext,
  input wire logic        tick_irq,
  input wire logic        watchdog_clear,
  input wire logic        watchdog_clock
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_reserved_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY |-> s_axi_rdata[31:8] == 24'h0
    && s_axi_rdata[5:4] == 2'h0 && !s_axi_rdata[0]) else $error("reserved bits set");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_wdog_select: assert property (
    watchdog_clear |-> $past(watchdog_clock_select_ext) == `WDT_SEL_PRESC_A
    || $past(watchdog_clock_select_ext) == `WDT_SEL_PRESC_B)
    else $error("watchdog cleared unselected");
  a_wdog_phase: assert property (
    watchdog_clear |-> watchdog_clock ##1 !watchdog_clear) else $error("watchdog clock phase");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !tick_irq && !s_axi_bvalid && !s_axi_rvalid && watchdog_clock)
    else $error("outputs busy after reset");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_irq: cover property ($rose(tick_irq));
  c_wdog: cover property (watchdog_clear);
endmodule

bind watch_interval_prescaler watch_tick_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_clock_select_ext(watchdog_clock_select_ext), .tick_irq(tick_irq),
  .watchdog_clear(watchdog_clear), .watchdog_clock(watchdog_clock));
`default_nettype wire

// >>> sub_source_model.sv
// count source model: sub oscillator and sub rc pulse trains with ready levels
`timescale 1ns/1ps
`default_nettype none
module sub_source_model #(
  parameter int PERIOD = 1
) (
  input  wire logic aclk,
  input  wire logic osc_en,
  input  wire logic rc_en,
  output logic      osc_pulse,
  output logic      rc_pulse,
  output logic      osc_ready,
  output logic      rc_ready
);
  int phase = 0;
  // a stopped source gives no pulses and drops ready at once, no wind-down
  always @(posedge aclk) begin
    phase <= (phase + 1) % PERIOD;
  end
  assign osc_pulse = osc_en && phase == 0;
  assign rc_pulse  = rc_en && phase == 0;
  assign osc_ready = osc_en;
  assign rc_ready  = rc_en;
endmodule
`default_nettype wire

// >>> watch_interval_prescaler_bench.sv
// self-checking bench of the watch tick prescaler
`timescale 1ns/1ps
`default_nettype none
`include "watch_tick_regs.svh"
module watch_interval_prescaler_bench;
  logic        aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [31:0] awa, wd, ara, rd;
  logic [1:0]  bresp, rresp;
  logic        osc_p, rc_p, osc_rdy, rc_rdy, osc_en, rc_en, sub_mode, stop;
  logic        irq, wd_clr, wd_clk;
  logic [2:0]  wsel;
  int          wd_cnt = 0;
  int          miscompares = 0;
  int          cmp_count = 0;

  watch_interval_prescaler u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .sub_osc_pulse(osc_p),
    .sub_rc_pulse(rc_p), .sub_osc_ready(osc_rdy), .sub_rc_ready(rc_rdy),
    .sub_clock_mode(sub_mode), .stop_mode(stop), .watchdog_clock_select_ext(wsel),
    .tick_irq(irq), .watchdog_clear(wd_clr), .watchdog_clock(wd_clk));

  sub_source_model #(.PERIOD(1)) u_src (
    .aclk(aclk), .osc_en(osc_en), .rc_en(rc_en), .osc_pulse(osc_p), .rc_pulse(rc_p),
    .osc_ready(osc_rdy), .rc_ready(rc_rdy));

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (aresetn && wd_clr) wd_cnt <= wd_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bready stays high throughout, so no release can collide with the next request
  task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    check({31'h0, bv}, 32'h1);
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // rready comes a cycle late on purpose, so the read data must stand
  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    check({31'h0, rv}, 32'h1);
    rr <= 1'b1;
    @(posedge aclk);
    rr <= 1'b0;
    check(rd, e);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_fields();
    rchk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    axi_wr(`CTRL_OFFSET, 8'h71, `RESP_OKAY);
    rchk(`CTRL_OFFSET, 32'h40, `RESP_OKAY);
    rchk(`CTRL_RMW_OFFSET, 32'hC0, `RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      axi_wr(`CTRL_OFFSET, {4'h0, c[2:0], 1'b0}, `RESP_OKAY);
      rchk(`CTRL_OFFSET, {28'h0, c[2:0], 1'b0}, `RESP_OKAY);
    end
    axi_wr(32'h10, 8'h40, `RESP_SLVERR);
    rchk(32'h10, 32'h0, `RESP_SLVERR);
    rchk(`CTRL_OFFSET, {28'h0, 3'h7, 1'b0}, `RESP_OKAY);
    $display("fields test done");
  endtask

  // the interval is 2^m count ticks of two source pulses, from the clear
  task automatic t_interval(input logic [2:0] code, input int m);
    int span;
    span = 2 << m;
    axi_wr(`CTRL_OFFSET, {4'h0, code, 1'b1}, `RESP_OKAY);
    idle(span - 40);
    rchk(`CTRL_OFFSET, {28'h0, code, 1'b0}, `RESP_OKAY);
    idle(80);
    rchk(`CTRL_OFFSET, {24'h0, 4'h8, code, 1'b0}, `RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    axi_wr(`CTRL_OFFSET, {4'hC, code, 1'b0}, `RESP_OKAY);
    idle(2);
    check({31'h0, irq}, 32'h1);
    axi_wr(`CTRL_OFFSET, {4'h4, code, 1'b0}, `RESP_OKAY);
    idle(2);
    check({31'h0, irq}, 32'h0);
    rchk(`CTRL_OFFSET, {24'h0, 4'h4, code, 1'b0}, `RESP_OKAY);
    $display("interval test done");
  endtask

  task automatic t_restart();
    axi_wr(`CTRL_OFFSET, 8'h09, `RESP_OKAY);
    idle(1500);
    axi_wr(`CTRL_OFFSET, 8'h09, `RESP_OKAY);
    idle(1000);
    rchk(`CTRL_OFFSET, 32'h08, `RESP_OKAY);
    idle(1100);
    rchk(`CTRL_OFFSET, 32'h88, `RESP_OKAY);
    $display("restart test done");
  endtask

  task automatic t_wdog();
    logic [2:0] sels [4];
    int         n0;
    sels = '{3'h4, 3'h6, 3'h0, 3'h5};
    for (int i = 0; i < 4; i++) begin
      wsel <= sels[i];
      idle(2);
      n0 = wd_cnt;
      axi_wr(`CTRL_OFFSET, 8'h09, `RESP_OKAY);
      idle(3);
      check(wd_cnt - n0, (sels[i] == 3'h4 || sels[i] == 3'h6) ? 1 : 0);
    end
    $display("watchdog test done");
  endtask

  task automatic t_stop();
    int n0;
    osc_en <= 1'b0;
    stop <= 1'b1;
    axi_wr(`CTRL_OFFSET, 8'h09, `RESP_OKAY);
    idle(2108);
    rchk(`CTRL_OFFSET, 32'h88, `RESP_OKAY);
    axi_wr(`CTRL_OFFSET, 8'h08, `RESP_OKAY);
    stop <= 1'b0;
    idle(2);
    sub_mode <= 1'b1;
    wsel <= 3'h4;
    idle(2);
    n0 = wd_cnt;
    stop <= 1'b1;
    idle(2200);
    rchk(`CTRL_OFFSET, 32'h08, `RESP_OKAY);
    check(wd_cnt - n0, 32'h1);
    stop <= 1'b0;
    sub_mode <= 1'b0;
    osc_en <= 1'b1;
    $display("stop test done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    {awv, wv, arv, rr, stop, sub_mode, aresetn} = '0;
    {awa, wd, ara} = '0;
    {br, osc_en, rc_en} = 3'h7;
    wsel = 3'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_fields();
    t_interval(3'h4, 10);
    t_interval(3'h0, 11);
    t_restart();
    t_wdog();
    t_stop();
    close_out();
  end

  // the run needs about 14300 cycles; allow well over twice that
  initial begin
    #1600000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
